// ==== kpil_pkg.sv ====
// shared constants and types of the keypad interrupt logic
package kpil_pkg;

    // number of port a keypad pins
    localparam int unsigned KPIL_PINS = 6;
    // avalon byte address width
    localparam int unsigned KPIL_ADDR_W = 5;

    // register byte offsets
    localparam logic [4:0] KPIL_OFS_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] KPIL_OFS_PIN_ENABLE = 5'h04;
    localparam logic [4:0] KPIL_OFS_IRQ_STATUS = 5'h08;
    localparam logic [4:0] KPIL_OFS_IRQ_MASK = 5'h0C;

    // keypad_status_control field positions
    localparam int unsigned KPIL_SC_PENDING = 0;
    localparam int unsigned KPIL_SC_MASK = 1;
    localparam int unsigned KPIL_SC_ACK = 2;
    localparam int unsigned KPIL_SC_LEVEL = 3;
    localparam int unsigned KPIL_SC_WAKE_PEND = 4;

    // keypad_pin_enable field positions
    localparam int unsigned KPIL_EN_WAKE = 6;

    // event status / mask field positions
    localparam int unsigned KPIL_EV_KEY = 0;
    localparam int unsigned KPIL_EV_WAKE = 1;
    localparam int unsigned KPIL_EV_W = 2;

    // reset values
    localparam logic [7:0] KPIL_RST_PIN_ENABLE = 8'h00;
    localparam logic KPIL_RST_MASK = 1'b0;
    localparam logic KPIL_RST_LEVEL = 1'b0;
    localparam logic [1:0] KPIL_RST_EVENTS = 2'h0;

    // cpu vector location of the keypad request
    localparam logic [15:0] KPIL_VECTOR_ADDR = 16'hFFE0;

    // register bus answer sequence
    typedef enum {
        KPIL_BUS_IDLE,
        KPIL_BUS_ANSWER,
        KPIL_BUS_RECOVER
    } kpil_bus_state_t;

endpackage : kpil_pkg

// ==== kpil_pin_sync.sv ====
// one keypad pin: two-flop synchroniser and falling edge detector
`timescale 1ns/1ps
`default_nettype none
module kpil_pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin,
    output logic level,
    output logic fall
);
    logic stage1; // first flop, read only by stage2
    logic stage2; // synchronised level
    logic prev; // previous synchronised sample

    // synchroniser chain and history sample
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            prev <= RESET_LEVEL;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            prev <= stage2;
        end
    end

    // falling edge: high before, low now
    assign fall = prev & ~stage2;
    assign level = stage2;

endmodule : kpil_pin_sync
`default_nettype wire

// ==== kpil_keypad.sv ====
// keypad interrupt logic with avalon-mm register slave
// Behaviour
// - level mode: edges and low levels count
// - level mode clear needs acknowledge and pins high
// - acknowledge and release may come either order
// - vector fetch acknowledges the keypad request
// - software acknowledge write acts like fetch on keypad request
// - later falling edge latches fresh request
// - unmasked pending request interrupts the cpu
// - level mode: request held while pin low
// - wakeup request cleared only by software
// - edge mode: acknowledge clears request at once
// - reset clears request and level mode
// - pending flag readable regardless of mask
// - per pin enable gates request latching
// - reset clears whole pin enable register
// - wakeup enable ignored by keypad pin path
`timescale 1ns/1ps
`default_nettype none
module kpil_keypad #(
    parameter int unsigned PINS = kpil_pkg::KPIL_PINS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [PINS-1:0] port_a_pins,
    input wire logic wakeup_pulse,
    input wire logic vector_fetch,
    input wire logic [kpil_pkg::KPIL_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic cpu_irq,
    output logic irq
);
    import kpil_pkg::*;

    // refuse pin counts the enable register cannot hold
    generate
        if (PINS < 1 || PINS > KPIL_EN_WAKE) begin : g_bad_pins
            $error("kpil_keypad: PINS must be 1 to 6");
        end
    endgenerate

    // synchronised pin state
    logic [PINS-1:0] pin_level; // synchronised pin levels
    logic [PINS-1:0] pin_fall; // one cycle falling edge pulses

    // software visible state
    logic [PINS-1:0] pin_enable; // per pin enables
    logic wakeup_enable; // wakeup source enable
    logic request_mask; // blocks cpu_irq only
    logic level_mode_select; // edge plus level sensitivity
    logic [KPIL_EV_W-1:0] event_status; // sticky event bits
    logic [KPIL_EV_W-1:0] event_mask; // event interrupt mask

    // request state
    logic key_req; // latched keypad request
    logic ack_held; // acknowledge seen, waiting for release
    logic wakeup_request; // latched wakeup request
    logic key_req_d; // previous key_req for event edge
    logic wake_req_d; // previous wakeup_request for event edge

    // bus state
    kpil_bus_state_t bus_state; // answer sequencer
    logic bus_req; // read or write offered
    logic wr_take; // write takes effect this edge
    logic rd_take; // read completes this edge
    logic [31:0] next_readdata; // read mux result

    // derived terms
    logic sw_ack; // software acknowledge write
    logic ack; // any keypad acknowledge
    logic any_edge; // enabled falling edge
    logic any_low; // enabled pin held low
    logic key_clear; // keypad request clears
    logic next_key_req; // next keypad request
    logic next_ack_held; // next acknowledge memory
    logic [KPIL_EV_W-1:0] ev_set; // event set pulses

    // one synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            kpil_pin_sync #(
                .RESET_LEVEL(1'b1)
            ) u_sync (
                .clk_sys(clk_sys),
                .rst(rst),
                .pin(port_a_pins[gi]),
                .level(pin_level[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    // bus handshake terms
    assign bus_req = avs_read | avs_write;
    assign wr_take = avs_write & (bus_state == KPIL_BUS_ANSWER);
    assign rd_take = avs_read & (bus_state == KPIL_BUS_ANSWER);

    // software acknowledge: write one to the ack bit
    assign sw_ack = wr_take & avs_byteenable[0] & (avs_address == KPIL_OFS_STATUS_CONTROL)
        & avs_writedata[KPIL_SC_ACK];

    // vector fetch and software write share one acknowledge
    assign ack = vector_fetch | sw_ack;

    // pin enables gate both edge and level terms; wakeup enable stays out
    assign any_edge = |(pin_fall & pin_enable);
    assign any_low = |(~pin_level & pin_enable);

    // clear condition per mode
    always_comb begin
        if (level_mode_select) begin
            key_clear = (ack | ack_held) & ~any_low;
        end else begin
            key_clear = ack;
        end
    end

    // next request: a new set wins over any clear
    always_comb begin
        next_key_req = key_req & ~key_clear;
        if (level_mode_select && any_low) begin
            next_key_req = 1'b1;
        end
        if (any_edge) begin
            next_key_req = 1'b1;
        end
    end

    // acknowledge memory for level mode, either order
    always_comb begin
        next_ack_held = ack_held;
        if (!level_mode_select || key_clear || any_edge) begin
            next_ack_held = 1'b0;
        end else if (ack && key_req) begin
            next_ack_held = 1'b1;
        end
    end

    // keypad request latch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_req <= 1'b0;
            ack_held <= 1'b0;
        end else begin
            key_req <= next_key_req;
            ack_held <= next_ack_held;
        end
    end

    // wakeup request: vector fetch does not clear it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wakeup_request <= 1'b0;
        end else if (wakeup_pulse && wakeup_enable) begin
            wakeup_request <= 1'b1; // set wins over clear
        end else if (sw_ack) begin
            wakeup_request <= 1'b0;
        end
    end

    // cpu request: pending and not masked, vector at KPIL_VECTOR_ADDR
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_irq <= 1'b0;
        end else begin
            cpu_irq <= (key_req | wakeup_request) & ~request_mask;
        end
    end

    // control register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            request_mask <= KPIL_RST_MASK;
            level_mode_select <= KPIL_RST_LEVEL;
        end else if (wr_take && avs_byteenable[0] && avs_address == KPIL_OFS_STATUS_CONTROL) begin
            request_mask <= avs_writedata[KPIL_SC_MASK];
            level_mode_select <= avs_writedata[KPIL_SC_LEVEL];
        end
    end

    // pin enable register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_enable <= KPIL_RST_PIN_ENABLE[PINS-1:0];
            wakeup_enable <= KPIL_RST_PIN_ENABLE[KPIL_EN_WAKE];
        end else if (wr_take && avs_byteenable[0] && avs_address == KPIL_OFS_PIN_ENABLE) begin
            pin_enable <= avs_writedata[PINS-1:0];
            wakeup_enable <= avs_writedata[KPIL_EN_WAKE];
        end
    end

    // event mask register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            event_mask <= KPIL_RST_EVENTS;
        end else if (wr_take && avs_byteenable[0] && avs_address == KPIL_OFS_IRQ_MASK) begin
            event_mask <= avs_writedata[KPIL_EV_W-1:0];
        end
    end

    // request rise detection for events
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_req_d <= 1'b0;
            wake_req_d <= 1'b0;
        end else begin
            key_req_d <= key_req;
            wake_req_d <= wakeup_request;
        end
    end

    assign ev_set = {wakeup_request & ~wake_req_d, key_req & ~key_req_d};

    // sticky events; a read clears only what it reported, new set wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            event_status <= KPIL_RST_EVENTS;
        end else if (rd_take && avs_address == KPIL_OFS_IRQ_STATUS) begin
            // readdata was captured one edge earlier; keep bits set since then
            event_status <= (event_status & ~avs_readdata[KPIL_EV_W-1:0]) | ev_set;
        end else begin
            event_status <= event_status | ev_set;
        end
    end

    // level interrupt from unmasked events
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_status & event_mask);
        end
    end

    // read mux; ack bit always reads zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            KPIL_OFS_STATUS_CONTROL: begin
                next_readdata[KPIL_SC_PENDING] = key_req | wakeup_request;
                next_readdata[KPIL_SC_MASK] = request_mask;
                next_readdata[KPIL_SC_LEVEL] = level_mode_select;
                next_readdata[KPIL_SC_WAKE_PEND] = wakeup_request;
            end
            KPIL_OFS_PIN_ENABLE: begin
                next_readdata[PINS-1:0] = pin_enable;
                next_readdata[KPIL_EN_WAKE] = wakeup_enable;
            end
            KPIL_OFS_IRQ_STATUS: begin
                next_readdata[KPIL_EV_W-1:0] = event_status;
            end
            KPIL_OFS_IRQ_MASK: begin
                next_readdata[KPIL_EV_W-1:0] = event_mask;
            end
            default: begin
                next_readdata = 32'h0000_0000; // unmapped reads zero
            end
        endcase
    end

    // bus sequencer: one wait cycle, answer, one recover cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_state <= KPIL_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            case (bus_state)
                KPIL_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state <= KPIL_BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= next_readdata;
                    end
                end
                KPIL_BUS_ANSWER: begin
                    bus_state <= KPIL_BUS_RECOVER;
                    avs_waitrequest <= 1'b1;
                end
                KPIL_BUS_RECOVER: begin
                    bus_state <= KPIL_BUS_IDLE;
                end
                default: begin
                    bus_state <= KPIL_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // checks on the bus answer and the request logic
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // request offered while idle
    sequence s_bus_offer;
        bus_req && bus_state == KPIL_BUS_IDLE;
    endsequence

    // answer then waitrequest back up
    sequence s_bus_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    // acknowledge taken while a pin is still low
    sequence s_ack_waiting;
        level_mode_select && key_req && ack && any_low && !any_edge;
    endsequence

    // stored acknowledge meets all enabled pins released
    sequence s_ack_release;
        level_mode_select && ack_held && !any_low && !any_edge;
    endsequence

    a_bus_answer_timing: assert property (s_bus_offer |=> s_bus_answer)
        else $error("bus answer not one cycle after offer");

    a_level_low_holds: assert property (level_mode_select && any_low |=> key_req)
        else $error("request dropped while enabled pin low");

    a_edge_latches: assert property (any_edge |=> key_req)
        else $error("enabled falling edge did not latch request");

    a_edge_mode_clear: assert property (!level_mode_select && key_req && ack && !any_edge |=> !key_req)
        else $error("edge mode acknowledge did not clear request");

    a_ack_stored: assert property (s_ack_waiting |=> ack_held)
        else $error("acknowledge not kept while pin low");

    a_ack_then_release: assert property (s_ack_release |=> !key_req)
        else $error("release after acknowledge did not clear request");

    a_release_needs_ack: assert property (level_mode_select && key_req && !ack && !ack_held |=> key_req)
        else $error("level request cleared without acknowledge");

    a_wakeup_fetch_kept: assert property (wakeup_request && vector_fetch && !sw_ack |=> wakeup_request)
        else $error("vector fetch cleared wakeup request");

    a_cpu_irq_follows: assert property (##1 cpu_irq == $past((key_req | wakeup_request) & ~request_mask))
        else $error("cpu request does not follow pending and mask");

    a_disabled_pin_quiet: assert property (pin_enable == '0 && !key_req && !$past(key_req) |=> !key_req)
        else $error("request latched with all pins disabled");

    a_reset_clears: assert property (@(posedge clk_sys) disable iff (1'b0)
        rst |=> !key_req && !level_mode_select && pin_enable == '0)
        else $error("reset left request, mode or enables set");

endmodule : kpil_keypad
`default_nettype wire

// ==== kpil_switches.sv ====
// keypad switch model standing on the port a pins
`timescale 1ns/1ps
`default_nettype none
module kpil_switches (
    input wire logic clk_sys,
    input wire logic [kpil_pkg::KPIL_PINS-1:0] press,
    input wire logic [1:0] lag,
    output logic [kpil_pkg::KPIL_PINS-1:0] port_a_pins
);
    import kpil_pkg::*;
    logic [KPIL_PINS-1:0] hist [0:3]; // contact history, one stage a cycle

    // contacts follow the key command after a selectable lag
    always_ff @(posedge clk_sys) begin
        hist[0] <= press;
        hist[1] <= hist[0];
        hist[2] <= hist[1];
        hist[3] <= hist[2];
    end

    // closed contact pulls low, open contact reads high through the pull-up
    assign port_a_pins = ~hist[lag];
endmodule : kpil_switches
`default_nettype wire

// ==== kpil_keypad_test.sv ====
// self-checking testbench of the keypad interrupt logic
`timescale 1ns/1ps
`default_nettype none
module kpil_keypad_test;
    import kpil_pkg::*;
    localparam logic [31:0] PEND = 32'h0000_0001 << KPIL_SC_PENDING; // pending flag
    localparam logic [31:0] MSK = 32'h0000_0001 << KPIL_SC_MASK; // request mask
    localparam logic [31:0] ACK = 32'h0000_0001 << KPIL_SC_ACK; // acknowledge
    localparam logic [31:0] LVL = 32'h0000_0001 << KPIL_SC_LEVEL; // level mode
    localparam logic [31:0] WPND = 32'h0000_0001 << KPIL_SC_WAKE_PEND; // wakeup request
    logic clk_sys = 1'b0; // system clock
    logic rst = 1'b1; // synchronous reset
    logic [KPIL_PINS-1:0] port_a_pins; // pins from the switch model
    logic [KPIL_PINS-1:0] press = '0; // keys held down
    logic [1:0] lag = 2'h0; // switch response delay
    logic wakeup_pulse = 1'b0; // wakeup event
    logic vector_fetch = 1'b0; // vector fetch pulse
    logic [KPIL_ADDR_W-1:0] avs_address = '0; // bus address
    logic avs_read = 1'b0; // bus read strobe
    logic avs_write = 1'b0; // bus write strobe
    logic [31:0] avs_writedata = 32'h0000_0000; // bus write data
    logic [3:0] avs_byteenable = 4'hF; // byte lanes
    logic [31:0] avs_readdata; // bus read data
    logic avs_waitrequest; // bus stall
    logic cpu_irq; // vector request
    logic irq; // event interrupt
    logic [31:0] exp_q[$]; // expected read data, oldest first
    int n_mismatch = 0; // mismatches seen
    int checked = 0; // comparisons made
    logic [31:0] seed = 32'h7017_0f5f; // random state
    int p; // enabled pin
    int q; // disabled pin

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    kpil_keypad uut (.clk_sys(clk_sys), .rst(rst), .port_a_pins(port_a_pins), .wakeup_pulse(wakeup_pulse),
        .vector_fetch(vector_fetch), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_irq(cpu_irq), .irq(irq));

    kpil_switches sw (.clk_sys(clk_sys), .press(press), .lag(lag), .port_a_pins(port_a_pins));

    // next random state
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // verdict and end of run
    task automatic report_and_stop;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // idle cycles
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_cyc

    // one bus access, held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [KPIL_ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        if (i >= 20) begin
            n_mismatch++;
            report_and_stop();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus_xfer

    // read with the expected word noted first
    task automatic bus_read(input logic [KPIL_ADDR_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus_xfer(1'b0, a, 32'h0000_0000);
    endtask : bus_read

    // one-cycle pulse of the vector fetch
    task automatic fetch;
        @(posedge clk_sys);
        vector_fetch <= 1'b1;
        @(posedge clk_sys);
        vector_fetch <= 1'b0;
    endtask : fetch

    // read data compared against the oldest note when the answer stands
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, avs_readdata, 32'h0000_0000);
            end else begin
                check(avs_readdata, exp_q.pop_front());
            end
        end
    end

    // hang guard
    initial begin
        wait_cyc(20000);
        n_mismatch++;
        report_and_stop();
    end

    // main sequence
    initial begin
        wait_cyc(4);
        rst <= 1'b0;
        bus_read(KPIL_OFS_STATUS_CONTROL, 32'h0000_0000);
        bus_read(KPIL_OFS_PIN_ENABLE, {24'h00_0000, KPIL_RST_PIN_ENABLE});
        bus_read(KPIL_OFS_IRQ_STATUS, 32'h0000_0000);
        bus_read(KPIL_OFS_IRQ_MASK, 32'h0000_0000);
        bus_xfer(1'b1, 5'h10, 32'h0000_00FF);
        bus_read(5'h10, 32'h0000_0000);
        $display("test reset done");
        seed = lfsr_next(seed);
        p = int'(seed[7:0]) % KPIL_PINS;
        q = (p + 1) % KPIL_PINS;
        lag <= seed[9:8];
        bus_xfer(1'b1, KPIL_OFS_IRQ_MASK, 32'h0000_0003);
        bus_xfer(1'b1, KPIL_OFS_PIN_ENABLE, 32'h0000_0001 << p);
        bus_read(KPIL_OFS_PIN_ENABLE, 32'h0000_0001 << p);
        press <= 6'h01 << q;
        wait_cyc(12);
        bus_read(KPIL_OFS_STATUS_CONTROL, 32'h0000_0000);
        press <= (6'h01 << q) | (6'h01 << p);
        wait_cyc(12);
        check({31'h0, cpu_irq}, 32'h0000_0001);
        bus_xfer(1'b1, KPIL_OFS_STATUS_CONTROL, MSK);
        wait_cyc(2);
        check({31'h0, cpu_irq}, 32'h0000_0000);
        bus_read(KPIL_OFS_STATUS_CONTROL, PEND | MSK);
        bus_xfer(1'b1, KPIL_OFS_STATUS_CONTROL, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) begin
                fetch();
            end else begin
                bus_xfer(1'b1, KPIL_OFS_STATUS_CONTROL, ACK);
            end
            wait_cyc(2);
            bus_read(KPIL_OFS_STATUS_CONTROL, 32'h0000_0000);
            press <= 6'h00;
            wait_cyc(12);
            press <= 6'h01 << p;
            wait_cyc(12);
            bus_read(KPIL_OFS_STATUS_CONTROL, PEND);
        end
        check({31'h0, irq}, 32'h0000_0001);
        bus_read(KPIL_OFS_IRQ_STATUS, 32'h0000_0001 << KPIL_EV_KEY);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test edge mode done");
        press <= 6'h00;
        wait_cyc(12);
        bus_xfer(1'b1, KPIL_OFS_STATUS_CONTROL, LVL | ACK);
        press <= 6'h01 << p;
        wait_cyc(12);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL | PEND);
        bus_xfer(1'b1, KPIL_OFS_STATUS_CONTROL, LVL | ACK);
        wait_cyc(4);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL | PEND);
        press <= 6'h00;
        wait_cyc(12);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL);
        press <= 6'h01 << p;
        wait_cyc(12);
        press <= 6'h00;
        wait_cyc(12);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL | PEND);
        fetch();
        wait_cyc(2);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL);
        $display("test level mode done");
        bus_xfer(1'b1, KPIL_OFS_PIN_ENABLE, 32'h0000_0001 << KPIL_EN_WAKE);
        press <= 6'h3F;
        wait_cyc(12);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL);
        @(posedge clk_sys);
        wakeup_pulse <= 1'b1;
        @(posedge clk_sys);
        wakeup_pulse <= 1'b0;
        wait_cyc(3);
        fetch();
        wait_cyc(2);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL | PEND | WPND);
        check({31'h0, irq}, 32'h0000_0001);
        bus_read(KPIL_OFS_IRQ_STATUS, 32'h0000_0003);
        bus_xfer(1'b1, KPIL_OFS_STATUS_CONTROL, LVL | ACK);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL);
        $display("test wakeup done");
        bus_xfer(1'b1, KPIL_OFS_PIN_ENABLE, 32'h0000_0001 << p);
        wait_cyc(12);
        bus_read(KPIL_OFS_STATUS_CONTROL, LVL | PEND);
        rst <= 1'b1;
        wait_cyc(4);
        rst <= 1'b0;
        wait_cyc(2);
        bus_read(KPIL_OFS_STATUS_CONTROL, 32'h0000_0000);
        bus_read(KPIL_OFS_PIN_ENABLE, 32'h0000_0000);
        bus_xfer(1'b1, KPIL_OFS_PIN_ENABLE, 32'h0000_0001 << p);
        bus_read(KPIL_OFS_STATUS_CONTROL, 32'h0000_0000);
        wait_cyc(2);
        check(exp_q.size(), 32'h0000_0000);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : kpil_keypad_test
`default_nettype wire
